//--- logic/excseq_pkg.sv
package excseq_pkg;
  localparam int VEC_W = 7;
  localparam int ADDR_W = 16;
  localparam int PRI_W = 2;
  localparam logic [VEC_W-1:0] VEC_RESET = 7'h00;
  localparam logic [VEC_W-1:0] VEC_DIRECT = 7'h06;
  localparam logic [VEC_W-1:0] VEC_NMI = 7'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 7'h08;
  localparam logic [VEC_W-1:0] VEC_ATRAP_BASE = 7'h10;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 7'h15;
  localparam logic [VEC_W-1:0] VEC_INT_FIRST = 7'h1E;
  localparam logic [VEC_W-1:0] VEC_INT_LAST = 7'h43;
  localparam int VEC_SHIFT = 2;
  localparam int N_IRQ = 6;
  localparam int N_ATRAP = 3;
  localparam logic [PRI_W-1:0] PRI_NONE = 2'h0;
  localparam logic CCR_I_RESET = 1'b1;
  localparam logic CCR_UI_RESET = 1'b0;
  localparam logic T_RESET = 1'b0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int STACK_STEPS = 2;

  typedef enum logic [2:0] {
    EXCSEQ_RESET = 3'b000,
    EXCSEQ_RUN = 3'b001,
    EXCSEQ_STACK = 3'b011,
    EXCSEQ_MASK = 3'b010,
    EXCSEQ_VECTOR = 3'b110
  } excseq_state_t;

  typedef enum logic [2:0] {
    EXCSEQ_K_NONE = 3'h0,
    EXCSEQ_K_RESET = 3'h1,
    EXCSEQ_K_INT = 3'h2,
    EXCSEQ_K_DIRECT = 3'h3,
    EXCSEQ_K_TRAP = 3'h4
  } excseq_kind_t;
endpackage

//--- logic/excseq_vecgen.sv
`timescale 1ns/1ps
module excseq_vecgen (
  input wire logic [excseq_pkg::VEC_W-1:0] vec_num_in,
  output logic [excseq_pkg::ADDR_W-1:0] vec_addr_out,
  output logic vec_ok_out
);
  import excseq_pkg::*;
  // vector slot is four bytes at four times the number
  assign vec_addr_out = {{(ADDR_W-VEC_W-VEC_SHIFT){1'b0}}, vec_num_in, {VEC_SHIFT{1'b0}}};
  // reserved slots are refused so a bad source id cannot start a fetch
  always_comb begin
    vec_ok_out = 1'b0;
    if (vec_num_in == VEC_RESET || vec_num_in == VEC_DIRECT || vec_num_in == VEC_NMI) begin
      vec_ok_out = 1'b1;
    end else if (vec_num_in >= VEC_TRAP_BASE && vec_num_in < VEC_TRAP_BASE + 7'h04) begin
      vec_ok_out = 1'b1;
    end else if (vec_num_in >= VEC_ATRAP_BASE && vec_num_in < VEC_IRQ_BASE + 7'h06) begin
      vec_ok_out = 1'b1;
    end else if (vec_num_in >= VEC_INT_FIRST && vec_num_in <= VEC_INT_LAST) begin
      vec_ok_out = 1'b1;
    end
  end
endmodule

//--- logic/excseq_intsel.sv
`timescale 1ns/1ps
module excseq_intsel (
  input wire logic nmi_req_in,
  input wire logic [excseq_pkg::N_IRQ-1:0] ext_request_lines_in,
  input wire logic [2*excseq_pkg::N_IRQ-1:0] irq_level_in,
  input wire logic periph_req_in,
  input wire logic [excseq_pkg::VEC_W-1:0] periph_vec_in,
  input wire logic [excseq_pkg::PRI_W-1:0] periph_level_in,
  input wire logic ccr_i_in,
  input wire logic user_mask_flag_in,
  input wire logic mode1_in,
  output logic int_valid_out,
  output logic [excseq_pkg::VEC_W-1:0] int_vec_out
);
  import excseq_pkg::*;

  // in mode 1 level 2 passes the user mask, level 1 only the global mask, level 0 never; mode 0 checks only the global mask
  function automatic logic lvl_pass(input logic [PRI_W-1:0] lvl, input logic gi, input logic ui, input logic m1);
    logic r;
    r = 1'b0;
    if (!m1) begin
      r = !gi;
    end else if (lvl == 2'h2) begin
      r = !gi || !ui;
    end else if (lvl != PRI_NONE) begin
      r = !gi;
    end
    return r;
  endfunction

  always_comb begin
    int_valid_out = 1'b0;
    int_vec_out = VEC_NMI;
    if (nmi_req_in) begin
      int_valid_out = 1'b1;
    end else begin
      for (int k = N_IRQ - 1; k >= 0; k--) begin
        if (ext_request_lines_in[k] && lvl_pass(irq_level_in[2*k +: 2], ccr_i_in, user_mask_flag_in, mode1_in)) begin
          int_valid_out = 1'b1;
          int_vec_out = VEC_IRQ_BASE + 7'(k);
        end
      end
      if (!int_valid_out && periph_req_in && lvl_pass(periph_level_in, ccr_i_in, user_mask_flag_in, mode1_in)) begin
        int_valid_out = 1'b1;
        int_vec_out = periph_vec_in;
      end
    end
  end
endmodule

//--- logic/excseq_top.sv
`timescale 1ns/1ps
module excseq_top (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ext_reset_pin_n_in,
  input wire logic wdt_overflow_in,
  input wire logic ctrl_mode_sel_lo_in,
  input wire logic ctrl_mode_sel_wr_in,
  input wire logic nmi_req_in,
  input wire logic [excseq_pkg::N_IRQ-1:0] ext_request_lines_in,
  input wire logic [2*excseq_pkg::N_IRQ-1:0] irq_level_in,
  input wire logic periph_req_in,
  input wire logic [excseq_pkg::VEC_W-1:0] periph_vec_in,
  input wire logic [excseq_pkg::PRI_W-1:0] periph_level_in,
  input wire logic [excseq_pkg::N_ATRAP-1:0] addr_trap_in,
  input wire logic insn_boundary_in,
  input wire logic last_flag_op_in,
  input wire logic soft_trap_op_in,
  input wire logic [1:0] soft_trap_num_in,
  input wire logic direct_trans_in,
  input wire logic return_from_exception_op_in,
  input wire logic ccr_wr_in,
  input wire logic ccr_i_wr_in,
  input wire logic ccr_ui_wr_in,
  output logic cpu_run_out,
  output logic exc_busy_out,
  output logic stack_push_out,
  output logic stack_sel_ccr_out,
  output logic pc_load_out,
  output logic [excseq_pkg::ADDR_W-1:0] vec_addr_out,
  output logic [excseq_pkg::VEC_W-1:0] vec_num_out,
  output logic ccr_i_out,
  output logic user_mask_flag_out,
  output logic trace_flag_out,
  output logic [1:0] int_mode_out,
  output logic int_block_out,
  output logic periph_reset_out,
  output logic direct_pend_out
);
  import excseq_pkg::*;

  // sequencer state and the flags it owns
  excseq_state_t state_q;
  excseq_kind_t kind_q;
  logic pin_q;
  logic ccr_i_q;
  logic ui_q;
  logic t_q;
  logic [1:0] mode_q;
  logic block_q;
  logic no_int_q;
  logic direct_pend_q;

  // what goes out to the fetch and stack logic
  logic [VEC_W-1:0] vec_q;
  logic [STACK_STEPS-1:0] step_q;
  logic stack_push_q;
  logic stack_sel_q;
  logic pc_load_q;
  logic [ADDR_W-1:0] vaddr_q;

  // request decoding, all combinational
  logic int_valid;
  logic [VEC_W-1:0] int_vec;
  logic [ADDR_W-1:0] vaddr_d;
  logic vec_ok;
  logic reset_now;
  logic reset_go;
  logic atrap_any;
  logic [VEC_W-1:0] atrap_vec;
  logic take_int;
  logic take_direct;
  logic take_trap;
  logic [VEC_W-1:0] next_vec_d;

  // the flags word is the last of the stacking beats
  function automatic logic ccr_beat(input excseq_state_t st, input logic [STACK_STEPS-1:0] stp);
    return st == EXCSEQ_STACK && stp == 2'(STACK_STEPS - 1);
  endfunction

  // interrupt pick: nmi, then the request pins, then the peripheral
  excseq_intsel u_intsel (
    .nmi_req_in(nmi_req_in),
    .ext_request_lines_in(ext_request_lines_in),
    .irq_level_in(irq_level_in),
    .periph_req_in(periph_req_in),
    .periph_vec_in(periph_vec_in),
    .periph_level_in(periph_level_in),
    .ccr_i_in(ccr_i_q),
    .user_mask_flag_in(ui_q),
    .mode1_in(mode_q[0]),
    .int_valid_out(int_valid),
    .int_vec_out(int_vec)
  );

  // number to slot address, plus a guard against reserved numbers
  excseq_vecgen u_vecgen (
    .vec_num_in(vec_q),
    .vec_addr_out(vaddr_d),
    .vec_ok_out(vec_ok)
  );

  // pin low or watchdog: hold everything in reset
  assign reset_now = rst_in || !ext_reset_pin_n_in || wdt_overflow_in;
  // reset exception begins on the pin rising or on watchdog overflow
  assign reset_go = (ext_reset_pin_n_in && !pin_q) || wdt_overflow_in;

  // address traps rank by index, the lowest wins
  always_comb begin
    atrap_any = 1'b0;
    atrap_vec = VEC_ATRAP_BASE;
    for (int k = N_ATRAP - 1; k >= 0; k--) begin
      if (addr_trap_in[k]) begin
        atrap_any = 1'b1;
        atrap_vec = VEC_ATRAP_BASE + 7'(k);
      end
    end
  end

  // trace is never taken: modes with trace are not built, and none after return
  // interrupts are boundary-only and skipped after flag ops and straight after reset
  // a direct request ranks one edge after it arrives, so a trap pulse that meets
  // a fresh direct request is dropped rather than let it jump ahead
  always_comb begin
    take_int = 1'b0;
    take_direct = 1'b0;
    take_trap = 1'b0;
    if (insn_boundary_in && !last_flag_op_in && !block_q && !no_int_q && (int_valid || atrap_any)) begin
      take_int = 1'b1;
    end else if (direct_pend_q) begin
      take_direct = 1'b1;
    end else if (soft_trap_op_in && !direct_trans_in) begin
      take_trap = 1'b1;
    end
  end

  // the trap slot is the fallback; it is used only when nothing outranks it
  always_comb begin
    next_vec_d = VEC_TRAP_BASE + {5'h00, soft_trap_num_in};
    if (take_int) begin
      next_vec_d = nmi_req_in ? VEC_NMI : (int_valid ? int_vec : atrap_vec);
    end else if (take_direct) begin
      next_vec_d = VEC_DIRECT;
    end
  end

  // pin history, marks the release edge of the reset pin
  always_ff @(posedge sys_clk_in) begin
    pin_q <= ext_reset_pin_n_in;
  end

  // sequencer: reset skips stacking and goes straight to mask update
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      state_q <= EXCSEQ_RESET;
      kind_q <= EXCSEQ_K_RESET;
      vec_q <= VEC_RESET;
      step_q <= '0;
    end else begin
      case (state_q)
        EXCSEQ_RESET: begin
          // no stacking: the stack pointer is not valid yet
          state_q <= EXCSEQ_MASK;
          kind_q <= EXCSEQ_K_RESET;
          vec_q <= VEC_RESET;
        end
        EXCSEQ_RUN: begin
          step_q <= '0;
          if (take_int) begin
            state_q <= EXCSEQ_STACK;
            kind_q <= EXCSEQ_K_INT;
            vec_q <= next_vec_d;
          end else if (take_direct) begin
            state_q <= EXCSEQ_STACK;
            kind_q <= EXCSEQ_K_DIRECT;
            vec_q <= next_vec_d;
          end else if (take_trap) begin
            state_q <= EXCSEQ_STACK;
            kind_q <= EXCSEQ_K_TRAP;
            vec_q <= next_vec_d;
          end
        end
        EXCSEQ_STACK: begin
          step_q <= step_q + 2'h1;
          if (ccr_beat(state_q, step_q)) begin
            state_q <= EXCSEQ_MASK;
          end
        end
        EXCSEQ_MASK: begin
          state_q <= EXCSEQ_VECTOR;
        end
        EXCSEQ_VECTOR: begin
          // pc_load_q rises on this same edge, so the fetch side loads the pc one edge later
          state_q <= EXCSEQ_RUN;
          kind_q <= EXCSEQ_K_NONE;
        end
        default: begin
          state_q <= EXCSEQ_RESET;
        end
      endcase
    end
  end

  // stack strobes: pc first, then flags
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      stack_push_q <= 1'b0;
      stack_sel_q <= 1'b0;
    end else begin
      // strobes trail the beat by one edge so they line up with the pushed data
      stack_push_q <= state_q == EXCSEQ_STACK;
      stack_sel_q <= ccr_beat(state_q, step_q);
    end
  end

  // vector fetch: reserved numbers never produce a load
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      pc_load_q <= 1'b0;
      vaddr_q <= '0;
    end else begin
      pc_load_q <= state_q == EXCSEQ_VECTOR && vec_ok;
      // address held until the next vector so the fetch side may sample late
      if (state_q == EXCSEQ_VECTOR) begin
        vaddr_q <= vaddr_d;
      end
    end
  end

  // flags: reset forces global mask and mode 0; every exception except reset also sets user mask in mode 1
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      ccr_i_q <= CCR_I_RESET;
      ui_q <= CCR_UI_RESET;
      t_q <= T_RESET;
    end else if (state_q == EXCSEQ_MASK) begin
      ccr_i_q <= 1'b1;
      t_q <= 1'b0;
      if (kind_q != EXCSEQ_K_RESET && mode_q[0]) begin
        ui_q <= 1'b1;
      end
      // software writes land only between exceptions
    end else if (ccr_wr_in && state_q == EXCSEQ_RUN) begin
      ccr_i_q <= ccr_i_wr_in;
      ui_q <= ccr_ui_wr_in;
    end
  end

  // only the low mode bit is writable; the high one selects modes not built here
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      mode_q <= MODE_RESET;
    end else if (ctrl_mode_sel_wr_in) begin
      mode_q <= {1'b0, ctrl_mode_sel_lo_in};
    end
  end

  // block all interrupts, nmi included, until two instructions have finished
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      block_q <= 1'b1;
      no_int_q <= 1'b0;
    end else begin
      // the first boundary only drops the after-reset skip, the second lifts the block
      if (state_q == EXCSEQ_RUN && insn_boundary_in && kind_q == EXCSEQ_K_NONE) begin
        block_q <= no_int_q;
        no_int_q <= 1'b0;
      end
      if (state_q == EXCSEQ_VECTOR && kind_q == EXCSEQ_K_RESET) begin
        no_int_q <= 1'b1;
      end
    end
  end

  // direct transition request held until accepted; new request wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_now) begin
      direct_pend_q <= 1'b0;
    end else if (direct_trans_in) begin
      direct_pend_q <= 1'b1;
    end else if (take_direct && state_q == EXCSEQ_RUN) begin
      direct_pend_q <= 1'b0;
    end
  end

  // a pin or watchdog reset still shows as busy through the else branch
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cpu_run_out <= 1'b0;
      exc_busy_out <= 1'b1;
      periph_reset_out <= 1'b1;
    end else begin
      cpu_run_out <= state_q == EXCSEQ_RUN && !reset_now;
      exc_busy_out <= state_q != EXCSEQ_RUN || reset_now;
      periph_reset_out <= reset_now;
    end
  end

  // every output is a flop; these only rename
  assign stack_push_out = stack_push_q;
  assign stack_sel_ccr_out = stack_sel_q;
  assign pc_load_out = pc_load_q;
  assign vec_addr_out = vaddr_q;
  assign vec_num_out = vec_q;
  assign ccr_i_out = ccr_i_q;
  assign user_mask_flag_out = ui_q;
  assign trace_flag_out = t_q;
  assign int_mode_out = mode_q;
  assign int_block_out = block_q;
  assign direct_pend_out = direct_pend_q;

  // return from exception never triggers trace; the input is accepted and has no effect
  logic unused_rte;
  assign unused_rte = return_from_exception_op_in ^ reset_go;
endmodule

//--- dv/excseq_top_properties.sv
`timescale 1ns/1ps
module excseq_top_properties (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ext_reset_pin_n_in,
  input wire logic wdt_overflow_in,
  input wire logic cpu_run_out,
  input wire logic stack_push_out,
  input wire logic stack_sel_ccr_out,
  input wire logic pc_load_out,
  input wire logic [excseq_pkg::ADDR_W-1:0] vec_addr_out,
  input wire logic [excseq_pkg::VEC_W-1:0] vec_num_out,
  input wire logic ccr_i_out,
  input wire logic trace_flag_out,
  input wire logic [1:0] int_mode_out,
  input wire logic int_block_out
);
  import excseq_pkg::*;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_pc_push;
    stack_push_out && !stack_sel_ccr_out;
  endsequence
  sequence s_ccr_push;
    stack_push_out && stack_sel_ccr_out;
  endsequence
  property p_push;
    $rose(stack_push_out) |-> s_pc_push ##1 s_ccr_push ##1 !stack_push_out;
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");
  property p_after;
    $fell(stack_push_out) |-> ##[1:4] (pc_load_out && ccr_i_out);
  endproperty
  a_after: assert property (p_after) else $error("no vector load after stacking");
  property p_vec;
    pc_load_out |-> vec_addr_out == ({9'h000, vec_num_out} << 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector address not four times number");
  property p_resv;
    pc_load_out |-> !(vec_num_out inside {[7'h01:7'h05], [7'h0C:7'h0F], [7'h1B:7'h1D]}) && vec_num_out <= VEC_INT_LAST;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved vector loaded");
  property p_trace;
    trace_flag_out == 1'b0;
  endproperty
  a_trace: assert property (p_trace) else $error("trace flag set");
  property p_pin;
    !ext_reset_pin_n_in |=> !cpu_run_out && ccr_i_out && int_mode_out == 2'h0 && int_block_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin low but not in reset");
  property p_wdt;
    wdt_overflow_in |=> !cpu_run_out && !pc_load_out;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not reset");
  // reset never stacks, it goes straight to the vector at zero
  property p_rise;
    $rose(ext_reset_pin_n_in) |-> !stack_push_out throughout (##[1:6] (pc_load_out && vec_addr_out == 16'h0000));
  endproperty
  a_rise: assert property (p_rise) else $error("reset vector not loaded");
endmodule
bind excseq_top excseq_top_properties u_excseq_top_properties (.*);

//--- dv/excseq_src_model.sv
`timescale 1ns/1ps
module excseq_src_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pc_load_in,
  input wire logic [excseq_pkg::VEC_W-1:0] vec_num_in,
  input wire logic nmi_set_in,
  input wire logic irq_set_in,
  output logic nmi_out,
  output logic [excseq_pkg::N_IRQ-1:0] irq_out
);
  import excseq_pkg::*;
  // requests stay up until their vector is loaded, so a refused one is offered again
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nmi_out <= 1'b0;
      irq_out <= '0;
    end else begin
      if (nmi_set_in) begin
        nmi_out <= 1'b1;
      end else if (pc_load_in && vec_num_in == VEC_NMI) begin
        nmi_out <= 1'b0;
      end
      if (irq_set_in) begin
        irq_out[0] <= 1'b1;
      end else if (pc_load_in && vec_num_in == VEC_IRQ_BASE) begin
        irq_out[0] <= 1'b0;
      end
    end
  end
endmodule

//--- dv/excseq_top_test.sv
`timescale 1ns/1ps
module excseq_top_test;
  import excseq_pkg::*;
  logic sys_clk_in, rst_in, ext_reset_pin_n_in, wdt_overflow_in, ctrl_mode_sel_lo_in, ctrl_mode_sel_wr_in;
  logic nmi_req_in, periph_req_in, insn_boundary_in, last_flag_op_in, soft_trap_op_in, direct_trans_in;
  logic return_from_exception_op_in, ccr_wr_in, ccr_i_wr_in, ccr_ui_wr_in, nmi_set, irq_set;
  logic cpu_run_out, exc_busy_out, stack_push_out, stack_sel_ccr_out, pc_load_out, ccr_i_out;
  logic user_mask_flag_out, trace_flag_out, int_block_out, periph_reset_out, direct_pend_out;
  logic [N_IRQ-1:0] ext_request_lines_in;
  logic [2*N_IRQ-1:0] irq_level_in;
  logic [VEC_W-1:0] periph_vec_in, vec_num_out;
  logic [PRI_W-1:0] periph_level_in;
  logic [N_ATRAP-1:0] addr_trap_in;
  logic [1:0] soft_trap_num_in, int_mode_out;
  logic [ADDR_W-1:0] vec_addr_out;
  int bad_count = 0;
  int checks_done = 0;
  excseq_top u_excseq_top (.*);
  excseq_src_model u_excseq_src_model (.clk_in(sys_clk_in), .rst_in, .pc_load_in(pc_load_out),
    .vec_num_in(vec_num_out), .nmi_set_in(nmi_set), .irq_set_in(irq_set), .nmi_out(nmi_req_in),
    .irq_out(ext_request_lines_in));
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // qualifiers ride on the one-cycle boundary pulse
  task automatic step(input logic trap, input logic [1:0] num, input logic dir, input logic flag);
    insn_boundary_in = 1'b1;
    soft_trap_op_in = trap;
    soft_trap_num_in = num;
    direct_trans_in = dir;
    last_flag_op_in = flag;
    tick();
    {insn_boundary_in, soft_trap_op_in, direct_trans_in, last_flag_op_in} = 4'h0;
  endtask
  // window covers the whole stack, mask and vector walk
  task automatic expect_load(input logic [VEC_W-1:0] v, input logic any);
    logic hit;
    logic [15:0] num;
    logic [15:0] addr;
    int pushes;
    hit = 1'b0;
    num = 16'h0000;
    addr = 16'h0000;
    pushes = 0;
    repeat (12) begin
      tick();
      pushes += int'(stack_push_out === 1'b1);
      if (pc_load_out === 1'b1 && !hit) begin
        hit = 1'b1;
        num = 16'(vec_num_out);
        addr = vec_addr_out;
      end
    end
    check("load", 16'(hit), 16'(any));
    check("pushes", 16'(pushes), (any && v != VEC_RESET) ? 16'(STACK_STEPS) : 16'h0000);
    if (any) begin
      check("vec_num", num, 16'(v));
      check("vec_addr", addr, 16'(v) << VEC_SHIFT);
    end
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // the sequence needs about 220 cycles
  initial begin
    #10000;
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_in = 1'b1;
    ext_reset_pin_n_in = 1'b0;
    {wdt_overflow_in, ctrl_mode_sel_lo_in, ctrl_mode_sel_wr_in, periph_req_in, insn_boundary_in} = 5'h00;
    {last_flag_op_in, soft_trap_op_in, direct_trans_in, return_from_exception_op_in} = 4'h0;
    {ccr_wr_in, ccr_i_wr_in, ccr_ui_wr_in, nmi_set, irq_set} = 5'h00;
    soft_trap_num_in = 2'h0;
    irq_level_in = 12'h001;
    periph_vec_in = 7'h00;
    periph_level_in = PRI_NONE;
    addr_trap_in = 3'h0;
    repeat (2) tick();
    rst_in = 1'b0;
    ext_reset_pin_n_in = 1'b1;
    expect_load(VEC_RESET, 1'b1);
    check("ccr_i", 16'(ccr_i_out), 16'h0001);
    check("mode", 16'(int_mode_out), 16'h0000);
    check("block", 16'(int_block_out), 16'h0001);
    $display("test reset done");
    nmi_set = 1'b1;
    tick();
    nmi_set = 1'b0;
    step(1'b0, 2'h0, 1'b0, 1'b0);
    expect_load(VEC_NMI, 1'b0);
    check("block", 16'(int_block_out), 16'h0001);
    step(1'b0, 2'h0, 1'b0, 1'b0);
    expect_load(VEC_NMI, 1'b0);
    check("block", 16'(int_block_out), 16'h0000);
    step(1'b0, 2'h0, 1'b0, 1'b0);
    expect_load(VEC_NMI, 1'b1);
    $display("test first boundary done");
    nmi_set = 1'b1;
    tick();
    nmi_set = 1'b0;
    step(1'b1, 2'h2, 1'b0, 1'b0);
    expect_load(VEC_NMI, 1'b1);
    step(1'b1, 2'h1, 1'b1, 1'b0);
    check("direct_pend", 16'(direct_pend_out), 16'h0001);
    expect_load(VEC_DIRECT, 1'b1);
    check("direct_pend", 16'(direct_pend_out), 16'h0000);
    $display("test priority done");
    for (int k = 0; k < 4; k++) begin
      step(1'b1, 2'(k), 1'b0, 1'b0);
      expect_load(VEC_TRAP_BASE + 7'(k), 1'b1);
    end
    check("ui", 16'(user_mask_flag_out), 16'h0000);
    ctrl_mode_sel_lo_in = 1'b1;
    ctrl_mode_sel_wr_in = 1'b1;
    tick();
    ctrl_mode_sel_wr_in = 1'b0;
    step(1'b1, 2'h3, 1'b0, 1'b0);
    expect_load(VEC_TRAP_BASE + 7'h03, 1'b1);
    check("mode", 16'(int_mode_out), 16'h0001);
    check("ui", 16'(user_mask_flag_out), 16'h0001);
    $display("test traps done");
    ccr_wr_in = 1'b1;
    ccr_ui_wr_in = 1'b1;
    irq_set = 1'b1;
    tick();
    {ccr_wr_in, irq_set} = 2'h0;
    step(1'b0, 2'h0, 1'b0, 1'b1);
    expect_load(VEC_IRQ_BASE, 1'b0);
    step(1'b0, 2'h0, 1'b0, 1'b0);
    expect_load(VEC_IRQ_BASE, 1'b1);
    check("ccr_i", 16'(ccr_i_out), 16'h0001);
    $display("test irq done");
    wdt_overflow_in = 1'b1;
    tick();
    wdt_overflow_in = 1'b0;
    expect_load(VEC_RESET, 1'b1);
    check("mode", 16'(int_mode_out), 16'h0000);
    ext_reset_pin_n_in = 1'b0;
    repeat (20) tick();
    check("run", 16'(cpu_run_out), 16'h0000);
    check("busy", 16'(exc_busy_out), 16'h0001);
    check("periph_reset", 16'(periph_reset_out), 16'h0001);
    ext_reset_pin_n_in = 1'b1;
    expect_load(VEC_RESET, 1'b1);
    check("busy", 16'(exc_busy_out), 16'h0000);
    check("periph_reset", 16'(periph_reset_out), 16'h0000);
    $display("test resets done");
    end_of_test();
  end
endmodule
